//--- pbsc_pkg.sv
// Shared constants and types for the special-cycle and 64-bit lane logic
package pbsc_pkg;
	// Bus commands as carried on the low command lanes
	localparam logic [3:0] PBSC_CMD_SPECIAL = 4'h1;
	localparam logic [3:0] PBSC_CMD_IO_RD   = 4'h2;
	localparam logic [3:0] PBSC_CMD_IO_WR   = 4'h3;
	localparam logic [3:0] PBSC_CMD_MEM_RD  = 4'h6;
	localparam logic [3:0] PBSC_CMD_MEM_WR  = 4'h7;
	localparam logic [3:0] PBSC_CMD_CFG_RD  = 4'ha;
	localparam logic [3:0] PBSC_CMD_CFG_WR  = 4'hb;
	localparam logic [3:0] PBSC_CMD_MEM_RM  = 4'hc;
	localparam logic [3:0] PBSC_CMD_DAC     = 4'hd;
	localparam logic [3:0] PBSC_CMD_MEM_RL  = 4'he;
	localparam logic [3:0] PBSC_CMD_MEM_WI  = 4'hf;

	// Type 1 configuration address layout
	localparam int         PBSC_TYPE_LO  = 0;
	localparam int         PBSC_REG_LO   = 2;
	localparam int         PBSC_FUNC_LO  = 8;
	localparam int         PBSC_DEV_LO   = 11;
	localparam int         PBSC_BUS_LO   = 16;
	localparam logic [1:0] PBSC_TYPE1    = 2'h1;
	localparam logic [5:0] PBSC_REG_ZERO = 6'h00;
	localparam logic [2:0] PBSC_FUNC_ALL = 3'h7;
	localparam logic [4:0] PBSC_DEV_ALL  = 5'h1f;

	// Quadword index inside a 32-byte cache line
	localparam int         PBSC_QW_LO  = 3;
	localparam logic [1:0] PBSC_QW_TOP = 2'h3;

	// Byte enables for the upper half of an odd-ending write and for all lanes of a wide read
	localparam logic [3:0] PBSC_BE_OFF = 4'hf;
	localparam logic [3:0] PBSC_BE_ALL = 4'h0;

	localparam int PBSC_SYNC_W = 3;

	typedef enum logic [1:0] {
		PBSC_IDLE,
		PBSC_GEN,
		PBSC_DONE
	} pbsc_sc_e;
endpackage

//--- pbsc_lanes.sv
// Address and data lane steering with upper-lane parity
`timescale 1ns/1ps
`default_nettype none
module pbsc_lanes
	import pbsc_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        wide,
	input  wire logic        bias,
	input  wire logic        addr_phase,
	input  wire logic        dac_first,
	input  wire logic        dac_second,
	input  wire logic [3:0]  cmd,
	input  wire logic [63:0] addr,
	input  wire logic        data_phase,
	input  wire logic        write,
	input  wire logic        ack64,
	input  wire logic        second,
	input  wire logic        last_odd,
	input  wire logic [63:0] data,
	input  wire logic [7:0]  be_n,
	output logic      [63:0] ad,
	output logic      [7:0]  cbe_n,
	output logic             par64
);
	typedef struct packed {
		logic [63:0] ad;
		logic [7:0]  cbe_n;
		logic        par64;
	} pbsc_lanes_s;

	pbsc_lanes_s st_reg;
	pbsc_lanes_s st_next;

	always_comb begin
		st_next = st_reg;
		// Parity trails the lanes it covers by one clock
		st_next.par64 = ^{st_reg.ad[63:32], st_reg.cbe_n[7:4]};
		// Idle lanes still sit at valid levels when nothing is attached
		st_next.ad = '0;
		st_next.cbe_n = '0;
		if (addr_phase) begin
			if (dac_first) begin
				st_next.ad = addr;
				st_next.cbe_n = {cmd, PBSC_CMD_DAC};
			end else if (dac_second) begin
				st_next.ad = {addr[63:32], addr[63:32]};
				st_next.cbe_n = {cmd, cmd};
			end else begin
				st_next.ad = {32'h0000_0000, addr[31:0]};
				st_next.cbe_n = {4'h0, cmd};
			end
		end else if (data_phase) begin
			if (!write && wide) begin
				st_next.ad = data;
				st_next.cbe_n = {2{PBSC_BE_ALL}};
			end else if (wide && ack64) begin
				st_next.ad = data;
				st_next.cbe_n = be_n;
				if (last_odd) begin
					st_next.ad[63:32] = 32'h0000_0000;
					st_next.cbe_n[7:4] = PBSC_BE_OFF;
				end
			end else if (wide && second) begin
				st_next.ad = {data[63:32], data[63:32]};
				st_next.cbe_n = {be_n[7:4], be_n[7:4]};
			end else begin
				st_next.ad = {32'h0000_0000, data[31:0]};
				st_next.cbe_n = {4'h0, be_n[3:0]};
			end
		end
		if (bias && !wide)
			st_next.cbe_n[7:4] = 4'h0;
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign ad = st_reg.ad;
	assign cbe_n = st_reg.cbe_n;
	assign par64 = st_reg.par64;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	sequence s_narrow_wr_second;
		data_phase && !addr_phase && write && wide && !ack64 && second;
	endsequence

	a_lane_redirect: assert property (
		s_narrow_wr_second |=> ad[31:0] == $past(data[63:32])
			&& cbe_n[3:0] == $past(be_n[7:4]))
		else $error("upper half not moved to lower lanes");

	a_read_be_zero: assert property (
		data_phase && !addr_phase && !write && wide |=> cbe_n == 8'h00)
		else $error("wide read byte enables not all zero");

	a_parity_follow: assert property (
		##1 par64 == ^{$past(ad[63:32]), $past(cbe_n[7:4])})
		else $error("upper parity does not cover previous lanes");
endmodule
`default_nettype wire

//--- pbsc_core.sv
// Special-cycle conversion and 64-bit negotiation for a two-port bridge
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Special cycles addressed to bridge are ignored
// - Config write, type 01, device 1Fh, function 7
// - Bus number matches secondary or primary register
// - Register number field must be zero
// - Command becomes special cycle, address/data unchanged
// - Delayed; master abort is success, then TRDY
// - Multiple data phases get first-phase disconnect
// - Special-cycle master abort sets no status
// - REQ64 follows FRAME timing exactly
// - Listed cases initiate as 32-bit
// - Resume after narrow disconnect stays 32-bit
// - Single address: upper lanes zero, valid
// - Dual address: upper address, memory command
// - ACK64 with DEVSEL gives 64-bit phases
// - Narrow write moves upper half down
// - Odd-ending write disables upper byte enables
// - Wide read drives all byte enables zero
// - Target withholds ACK64 in listed cases
// - Wide target moves 64 bits, drives PAR64
// - Odd dwords with ACK64: disconnect before last
// - Primary REQ64 sampled in reset sets width
// - Secondary REQ64 held low during secondary reset
module pbsc_core
	import pbsc_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        up_bus_rst_n,
	input  wire logic        dn_bus_rst_n,
	input  wire logic        upstream_wide_request_n,
	input  wire logic [7:0]  up_bus_num,
	input  wire logic [7:0]  dn_bus_num,
	input  wire logic        tgt_cyc,
	input  wire logic        tgt_up,
	input  wire logic [3:0]  tgt_cmd,
	input  wire logic [31:0] tgt_ad,
	input  wire logic [31:0] tgt_data,
	input  wire logic        tgt_req64_n,
	input  wire logic        tgt_multi,
	input  wire logic        tgt_one_dw,
	input  wire logic        tgt_rd_phase,
	input  wire logic [7:0]  tgt_rd_left,
	output logic             tgt_claim,
	output logic             tgt_trdy,
	output logic             tgt_stop,
	output logic             tgt_ignore,
	output logic             tgt_ack64,
	output logic             tgt_disc_early,
	output logic             ini_start,
	output logic             ini_up,
	output logic      [3:0]  ini_cmd,
	output logic      [31:0] ini_ad,
	output logic      [31:0] ini_msg,
	input  wire logic        ini_end,
	input  wire logic        ini_mabort,
	output logic             rma_set,
	input  wire logic        req_valid,
	input  wire logic        req_up,
	input  wire logic [3:0]  req_cmd,
	input  wire logic [4:0]  req_addr_lo,
	input  wire logic [7:0]  req_dwords,
	input  wire logic        req_prefetch,
	input  wire logic        req_resume,
	input  wire logic        req_prev_ack64,
	input  wire logic        req_prev_retry,
	input  wire logic        frame_drive,
	output logic             frame_n,
	output logic             use64,
	output logic             up_wide_ok,
	output logic             up_wide_req_n_o,
	output logic             up_wide_req_n_oe,
	output logic             dn_wide_req_n_o,
	output logic             dn_wide_req_n_oe,
	input  wire logic        ln_addr_phase,
	input  wire logic        ln_dac_first,
	input  wire logic        ln_dac_second,
	input  wire logic [63:0] ln_addr,
	input  wire logic        ln_data_phase,
	input  wire logic        ln_write,
	input  wire logic        ln_ack64,
	input  wire logic        ln_second,
	input  wire logic        ln_last_odd,
	input  wire logic [63:0] ln_data,
	input  wire logic [7:0]  ln_be_n,
	output logic      [63:0] ln_ad,
	output logic      [7:0]  ln_cbe_n,
	output logic             ln_par64
);
	typedef struct packed {
		logic [2:0]  ur_s;
		logic        ur;
		logic [2:0]  dr_s;
		logic        dr;
		logic [2:0]  w_s;
		logic        w;
		logic        ext64;
		pbsc_sc_e    state;
		logic        sc_up;
		logic [31:0] sc_ad;
		logic        t_claim;
		logic        t_trdy;
		logic        t_stop;
		logic        t_ign;
		logic        t_ack64;
		logic        t_wide;
		logic        t_disc;
		logic        i_start;
		logic        i_up;
		logic [31:0] i_ad;
		logic [31:0] i_msg;
		logic        rma;
		logic        use64;
		logic        req_up;
		logic        frame_n;
		logic        up_o;
		logic        up_oe;
		logic        dn_o;
		logic        dn_oe;
	} pbsc_core_s;

	pbsc_core_s st_reg;
	pbsc_core_s st_next;
	logic       sc_hit;
	logic       wide_now;

	function automatic logic sc_match(input logic [3:0] cmd,
		input logic [31:0] a, input logic [7:0] bus);
		sc_match = cmd == PBSC_CMD_CFG_WR
			&& a[PBSC_TYPE_LO +: 2] == PBSC_TYPE1
			&& a[PBSC_DEV_LO +: 5] == PBSC_DEV_ALL
			&& a[PBSC_FUNC_LO +: 3] == PBSC_FUNC_ALL
			&& a[PBSC_REG_LO +: 6] == PBSC_REG_ZERO
			&& a[PBSC_BUS_LO +: 8] == bus;
	endfunction

	function automatic logic wide_init(input logic [3:0] cmd,
		input logic [4:0] alo, input logic [7:0] dw, input logic pf,
		input logic up, input logic ext);
		logic wr;
		logic rd;
		wr = cmd == PBSC_CMD_MEM_WR || cmd == PBSC_CMD_MEM_WI;
		rd = cmd == PBSC_CMD_MEM_RM || cmd == PBSC_CMD_MEM_RL
			|| (cmd == PBSC_CMD_MEM_RD && pf);
		wide_init = ((wr && dw > 8'd2) || (rd && dw > 8'd1))
			&& alo[PBSC_QW_LO-1:0] == 3'h0
			&& alo[PBSC_QW_LO +: 2] != PBSC_QW_TOP
			&& !(up && !ext);
	endfunction

	// Downstream matches secondary number, upstream the primary one
	assign sc_hit = sc_match(tgt_cmd, tgt_ad, tgt_up ? up_bus_num
		: dn_bus_num);
	assign wide_now = wide_init(req_cmd, req_addr_lo, req_dwords,
		req_prefetch, req_up, st_reg.ext64)
		&& !(req_resume && !req_prev_ack64 && !req_prev_retry);

	always_comb begin
		st_next = st_reg;
		st_next.t_claim = 1'b0;
		st_next.t_trdy = 1'b0;
		st_next.t_stop = 1'b0;
		st_next.t_ign = 1'b0;
		st_next.t_ack64 = 1'b0;
		st_next.t_disc = 1'b0;
		st_next.i_start = 1'b0;
		st_next.rma = 1'b0;

		// Pin levels count once the second and third stages agree
		st_next.ur_s = {st_reg.ur_s[1:0], up_bus_rst_n};
		st_next.dr_s = {st_reg.dr_s[1:0], dn_bus_rst_n};
		st_next.w_s = {st_reg.w_s[1:0], upstream_wide_request_n};
		if (st_reg.ur_s[1] == st_reg.ur_s[2])
			st_next.ur = st_reg.ur_s[2];
		if (st_reg.dr_s[1] == st_reg.dr_s[2])
			st_next.dr = st_reg.dr_s[2];
		if (st_reg.w_s[1] == st_reg.w_s[2])
			st_next.w = st_reg.w_s[2];
		// Width keeps tracking the strap while primary reset is held
		if (!st_reg.ur)
			st_next.ext64 = !st_reg.w;

		if (tgt_cyc) begin
			if (tgt_cmd == PBSC_CMD_SPECIAL) begin
				st_next.t_ign = 1'b1;
			end else if (sc_hit) begin
				st_next.t_claim = 1'b1;
				case (st_reg.state)
				PBSC_IDLE: begin
					// First attempt is retried while the cycle runs
					st_next.t_stop = 1'b1;
					st_next.state = PBSC_GEN;
					st_next.sc_up = tgt_up;
					st_next.sc_ad = tgt_ad;
					st_next.i_start = 1'b1;
					st_next.i_up = !tgt_up ? 1'b0 : 1'b1;
					st_next.i_ad = tgt_ad;
					st_next.i_msg = tgt_data;
				end
				PBSC_DONE: begin
					if (tgt_ad == st_reg.sc_ad
						&& tgt_up == st_reg.sc_up) begin
						st_next.t_trdy = 1'b1;
						st_next.t_stop = tgt_multi;
						st_next.state = PBSC_IDLE;
					end else begin
						st_next.t_stop = 1'b1;
					end
				end
				default: begin
					st_next.t_stop = 1'b1;
				end
				endcase
			end else begin
				st_next.t_ack64 = !tgt_req64_n
					&& !(tgt_up ? 1'b0 : !st_reg.ext64)
					&& !tgt_one_dw
					&& tgt_cmd != PBSC_CMD_MEM_RD
					&& tgt_cmd != PBSC_CMD_IO_RD
					&& tgt_cmd != PBSC_CMD_IO_WR
					&& tgt_cmd != PBSC_CMD_CFG_RD
					&& tgt_cmd != PBSC_CMD_CFG_WR;
				st_next.t_wide = st_next.t_ack64;
			end
		end

		// Odd leftover dword cannot ride a 64-bit phase
		if (tgt_rd_phase)
			st_next.t_disc = st_reg.t_wide && tgt_rd_left == 8'd1;

		if (ini_end) begin
			if (st_reg.state == PBSC_GEN)
				st_next.state = PBSC_DONE;
			else
				st_next.rma = ini_mabort;
		end

		if (req_valid) begin
			st_next.use64 = wide_now;
			st_next.req_up = req_up;
		end
		st_next.frame_n = !frame_drive;
		st_next.up_o = !(frame_drive && st_next.use64
			&& st_next.req_up);
		st_next.up_oe = (frame_drive && st_next.req_up)
			|| !st_reg.ext64;
		st_next.dn_o = !(frame_drive && st_next.use64
			&& !st_next.req_up);
		st_next.dn_oe = frame_drive && !st_next.req_up;
		if (!st_reg.dr) begin
			st_next.dn_o = 1'b0;
			st_next.dn_oe = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_reg <= '0;
			st_reg.ur_s <= 3'h7;
			st_reg.ur <= 1'b1;
			st_reg.dr_s <= 3'h7;
			st_reg.dr <= 1'b1;
			st_reg.w_s <= 3'h7;
			st_reg.w <= 1'b1;
			st_reg.state <= PBSC_IDLE;
			st_reg.frame_n <= 1'b1;
			st_reg.up_o <= 1'b1;
			st_reg.dn_o <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tgt_claim = st_reg.t_claim;
	assign tgt_trdy = st_reg.t_trdy;
	assign tgt_stop = st_reg.t_stop;
	assign tgt_ignore = st_reg.t_ign;
	assign tgt_ack64 = st_reg.t_ack64;
	assign tgt_disc_early = st_reg.t_disc;
	assign ini_start = st_reg.i_start;
	assign ini_up = st_reg.i_up;
	// Only the command lane changes; address and message pass as is
	assign ini_cmd = PBSC_CMD_SPECIAL;
	assign ini_ad = st_reg.i_ad;
	assign ini_msg = st_reg.i_msg;
	assign rma_set = st_reg.rma;
	assign frame_n = st_reg.frame_n;
	assign use64 = st_reg.use64;
	assign up_wide_ok = st_reg.ext64;
	assign up_wide_req_n_o = st_reg.up_o;
	assign up_wide_req_n_oe = st_reg.up_oe;
	assign dn_wide_req_n_o = st_reg.dn_o;
	assign dn_wide_req_n_oe = st_reg.dn_oe;

	pbsc_lanes u_lanes (
		.ref_clk    (ref_clk),
		.sys_rst    (sys_rst),
		.wide       (st_reg.use64),
		.bias       (!st_reg.ext64),
		.addr_phase (ln_addr_phase),
		.dac_first  (ln_dac_first),
		.dac_second (ln_dac_second),
		.cmd        (req_cmd),
		.addr       (ln_addr),
		.data_phase (ln_data_phase),
		.write      (ln_write),
		.ack64      (ln_ack64),
		.second     (ln_second),
		.last_odd   (ln_last_odd),
		.data       (ln_data),
		.be_n       (ln_be_n),
		.ad         (ln_ad),
		.cbe_n      (ln_cbe_n),
		.par64      (ln_par64)
	);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	sequence s_first_try;
		tgt_cyc && sc_hit && tgt_cmd != PBSC_CMD_SPECIAL
			&& st_reg.state == PBSC_IDLE;
	endsequence

	sequence s_repeat_try;
		tgt_cyc && sc_hit && st_reg.state == PBSC_DONE
			&& tgt_ad == st_reg.sc_ad && tgt_up == st_reg.sc_up;
	endsequence

	a_special_ignored: assert property (
		tgt_cyc && tgt_cmd == PBSC_CMD_SPECIAL
			|=> tgt_ignore && !tgt_claim && !ini_start)
		else $error("special cycle was claimed or forwarded");

	a_no_false_hit: assert property (
		tgt_cyc && !sc_hit |=> !tgt_claim && !ini_start)
		else $error("non-qualifying write started a special cycle");

	a_cmd_swap: assert property (
		s_first_try |=> ini_start && ini_cmd == PBSC_CMD_SPECIAL
			&& ini_ad == $past(tgt_ad) && ini_msg == $past(tgt_data))
		else $error("special cycle not issued unchanged");

	a_first_retry: assert property (
		s_first_try |=> tgt_stop && !tgt_trdy)
		else $error("first attempt not retried");

	a_repeat_done: assert property (
		s_repeat_try |=> tgt_trdy && tgt_stop == $past(tgt_multi))
		else $error("repeat attempt not completed correctly");

	a_rma_quiet: assert property (
		ini_end && st_reg.state == PBSC_GEN |=> !rma_set)
		else $error("special cycle abort set status");

	a_req64_frame: assert property (
		$past(st_reg.dr) && st_reg.use64 && !st_reg.req_up
			|-> dn_wide_req_n_o == frame_n)
		else $error("request width strobe differs from frame");

	a_up_narrow: assert property (
		req_valid && req_up && !st_reg.ext64 |=> !use64)
		else $error("wide upstream initiation without extension");

	a_wide_refuse: assert property (
		tgt_cyc && (tgt_req64_n || tgt_cmd == PBSC_CMD_IO_WR
			|| tgt_one_dw) |=> !tgt_ack64)
		else $error("wide acknowledge given when refused");

	a_dn_reset_low: assert property (
		!$past(st_reg.dr) |-> !dn_wide_req_n_o && dn_wide_req_n_oe)
		else $error("secondary width request not low in reset");
endmodule
`default_nettype wire

//--- pbsc_far_model.sv
// Far-bus model: no device claims a special cycle, so it master-aborts
`timescale 1ns/1ps
`default_nettype none
module pbsc_far_model
	import pbsc_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	input  wire logic       ini_start,
	input  wire logic [3:0] ini_cmd,
	input  wire logic       slow,
	output logic            ini_end,
	output logic            ini_mabort,
	output int              n_starts
);
	int wait_cnt;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wait_cnt   <= 0;
			ini_end    <= 1'b0;
			ini_mabort <= 1'b0;
			n_starts   <= 0;
		end else begin
			ini_end <= 1'b0;
			// Abort flag is meaningless between ends, so keep it moving
			ini_mabort <= ~ini_mabort;
			if (ini_start) begin
				n_starts <= n_starts + 1;
				wait_cnt <= slow ? 9 : 2;
			end else if (wait_cnt == 1) begin
				wait_cnt   <= 0;
				ini_end    <= 1'b1;
				ini_mabort <= (ini_cmd == PBSC_CMD_SPECIAL);
			end else if (wait_cnt > 1) begin
				wait_cnt <= wait_cnt - 1;
			end
		end
	end
endmodule
`default_nettype wire

//--- tb_pbsc_core.sv
// Self-checking bench for special-cycle and 64-bit lane logic
`timescale 1ns/1ps
`default_nettype none
module tb_pbsc_core;
	import pbsc_pkg::*;
	logic        ref_clk, sys_rst, up_bus_rst_n, dn_bus_rst_n, slow;
	logic        upstream_wide_request_n, tgt_cyc, tgt_up, tgt_req64_n;
	logic        tgt_multi, tgt_one_dw, tgt_rd_phase, tgt_claim, tgt_trdy;
	logic        tgt_stop, tgt_ignore, tgt_ack64, tgt_disc_early, ini_start;
	logic        ini_up, ini_end, ini_mabort, rma_set, req_valid, req_up;
	logic        req_prefetch, req_resume, req_prev_ack64, req_prev_retry;
	logic        frame_drive, frame_n, use64, up_wide_ok, up_wide_req_n_o;
	logic        up_wide_req_n_oe, dn_wide_req_n_o, dn_wide_req_n_oe;
	logic        ln_addr_phase, ln_dac_first, ln_dac_second, ln_data_phase;
	logic        ln_write, ln_ack64, ln_second, ln_last_odd, ln_par64;
	logic        wide_up;
	logic [3:0]  tgt_cmd, ini_cmd, req_cmd;
	logic [4:0]  req_addr_lo;
	logic [7:0]  up_bus_num, dn_bus_num, tgt_rd_left, req_dwords;
	logic [7:0]  ln_be_n, ln_cbe_n;
	logic [31:0] tgt_ad, tgt_data, ini_ad, ini_msg;
	logic [63:0] ln_addr, ln_data, ln_ad;
	int          miscompares, n_checks, n_starts, n_ends, n_rma, cycles;

	pbsc_core pbsc_core_i (.ref_clk, .sys_rst, .up_bus_rst_n, .dn_bus_rst_n,
		.upstream_wide_request_n, .up_bus_num, .dn_bus_num, .tgt_cyc,
		.tgt_up, .tgt_cmd, .tgt_ad, .tgt_data, .tgt_req64_n, .tgt_multi,
		.tgt_one_dw, .tgt_rd_phase, .tgt_rd_left, .tgt_claim, .tgt_trdy,
		.tgt_stop, .tgt_ignore, .tgt_ack64, .tgt_disc_early, .ini_start,
		.ini_up, .ini_cmd, .ini_ad, .ini_msg, .ini_end, .ini_mabort, .rma_set,
		.req_valid, .req_up, .req_cmd, .req_addr_lo, .req_dwords,
		.req_prefetch, .req_resume, .req_prev_ack64, .req_prev_retry,
		.frame_drive, .frame_n, .use64, .up_wide_ok, .up_wide_req_n_o,
		.up_wide_req_n_oe, .dn_wide_req_n_o, .dn_wide_req_n_oe,
		.ln_addr_phase, .ln_dac_first, .ln_dac_second, .ln_addr,
		.ln_data_phase, .ln_write, .ln_ack64, .ln_second, .ln_last_odd,
		.ln_data, .ln_be_n, .ln_ad, .ln_cbe_n, .ln_par64);
	pbsc_far_model pbsc_far_model_i (.ref_clk, .sys_rst, .ini_start,
		.ini_cmd, .slow, .ini_end, .ini_mabort, .n_starts);

	always #50 ref_clk = ~ref_clk;

	// Whole run needs under 2000 cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (ini_end === 1'b1)
			n_ends++;
		if (!sys_rst && rma_set !== 1'b0)
			n_rma++;
		if (cycles == 5000) begin
			miscompares++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("checks=%0d miscompares=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [71:0] got, input logic [71:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tgt(input logic up, input logic [3:0] c,
			input logic [31:0] a, input logic [31:0] d, input logic m,
			input logic r, input logic one);
		@(posedge ref_clk);
		{tgt_up, tgt_cmd, tgt_ad, tgt_data} <= {up, c, a, d};
		{tgt_multi, tgt_req64_n, tgt_one_dw, tgt_cyc} <= {m, r, one, 1'b1};
		@(posedge ref_clk);
		tgt_cyc <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] left);
		@(posedge ref_clk);
		tgt_rd_left  <= left;
		tgt_rd_phase <= 1'b1;
		@(posedge ref_clk);
		tgt_rd_phase <= 1'b0;
		#1;
	endtask

	function automatic logic exp_wide(input logic up, input logic [3:0] c,
			input logic [4:0] a, input logic [7:0] dw, input logic pf,
			input logic rs, input logic pa, input logic pr);
		logic mw, mr;
		mw = c == PBSC_CMD_MEM_WR || c == PBSC_CMD_MEM_WI;
		mr = pf && (c == PBSC_CMD_MEM_RL || c == PBSC_CMD_MEM_RM);
		return (mw && dw > 2 || mr && dw > 1) && a[2:0] == 3'h0 &&
			a[4:3] != PBSC_QW_TOP && !(rs && !pa && !pr) && (!up || wide_up);
	endfunction

	task automatic ini_one(input logic up, input logic [3:0] c,
			input logic [4:0] a, input logic [7:0] dw, input logic pf,
			input logic rs, input logic pa, input logic pr);
		logic w;
		w = exp_wide(up, c, a, dw, pf, rs, pa, pr);
		@(posedge ref_clk);
		{req_up, req_cmd, req_addr_lo, req_dwords} <= {up, c, a, dw};
		{req_prefetch, req_resume, req_prev_ack64} <= {pf, rs, pa};
		req_prev_retry <= pr;
		req_valid      <= 1'b1;
		@(posedge ref_clk);
		req_valid   <= 1'b0;
		frame_drive <= 1'b1;
		@(posedge ref_clk);
		frame_drive <= 1'b0;
		#1;
		chk(use64, w);
		chk(frame_n, 0);
		chk(up ? up_wide_req_n_o : dn_wide_req_n_o, !w);
		@(posedge ref_clk);
		#1;
		chk(up ? up_wide_req_n_o : dn_wide_req_n_o, 1);
	endtask

	task automatic ini_rand(input int n);
		logic [3:0] c;
		for (int i = 0; i < n; i++) begin
			c = 4'($urandom);
			ini_one(1'($urandom), c, 5'($urandom), 8'($urandom_range(1, 9)),
				c != PBSC_CMD_MEM_RD && $urandom % 2 == 1, 1'($urandom),
				1'($urandom), 1'($urandom));
		end
		$display("initiator batch done");
	endtask

	task automatic sc_test(input logic up, input logic m);
		logic [31:0] a, d;
		a = {8'($urandom), up ? up_bus_num : dn_bus_num, PBSC_DEV_ALL,
			PBSC_FUNC_ALL, PBSC_REG_ZERO, PBSC_TYPE1};
		d = $urandom;
		slow = $urandom % 2;
		tgt(up, PBSC_CMD_CFG_WR, a, d, m, 1'b1, 1'b0);
		chk({tgt_claim, tgt_stop, tgt_trdy, ini_start}, 4'hd);
		chk({ini_up, ini_cmd}, {up, PBSC_CMD_SPECIAL});
		chk({ini_ad, ini_msg}, {a, d});
		tgt(up, PBSC_CMD_CFG_WR, a, d, m, 1'b1, 1'b0);
		chk({tgt_claim, tgt_stop, tgt_trdy, ini_start}, 4'hc);
		for (int i = 0; i < 30 && n_ends < n_starts; i++)
			@(posedge ref_clk);
		chk(n_ends, n_starts);
		tgt(up, PBSC_CMD_CFG_WR, a, d, m, 1'b1, 1'b0);
		chk({tgt_claim, tgt_trdy, tgt_stop, ini_start}, {2'h3, m, 1'b0});
		$display("special cycle test done");
	endtask

	task automatic lane(input int m);
		logic [6:0]  ph [7] = '{7'h40, 7'h60, 7'h1c, 7'h1a, 7'h10, 7'h1d,
			7'h40};
		logic [63:0] d;
		logic [7:0]  b;
		d = {$urandom, $urandom};
		b = $urandom;
		@(posedge ref_clk);
		{ln_addr_phase, ln_dac_first, ln_data_phase, ln_write} <= ph[m][6:3];
		{ln_ack64, ln_second, ln_last_odd} <= ph[m][2:0];
		ln_dac_second <= m == 6;
		{ln_addr, ln_data, ln_be_n} <= {d, d, b};
		@(posedge ref_clk);
		#1;
		case (m)
		0: chk({ln_ad, ln_cbe_n[3:0]}, {32'h0, d[31:0], req_cmd});
		1: chk({ln_ad, ln_cbe_n[7:4]}, {d, req_cmd});
		2: chk({ln_ad, ln_cbe_n}, {d, b});
		3: chk({ln_ad[31:0], ln_cbe_n[3:0]}, {d[63:32], b[7:4]});
		4: chk(ln_cbe_n, 8'h00);
		5: chk({ln_ad[31:0], ln_cbe_n}, {d[31:0], 4'hf, b[3:0]});
		default: chk({ln_ad[63:32], ln_cbe_n[7:4]},
			{d[63:32], req_cmd});
		endcase
		@(posedge ref_clk);
		#1;
		if (m == 2)
			chk(ln_par64, ^{d[63:32], b[7:4]});
	endtask

	initial begin
		logic [31:0] a;
		logic [3:0]  c;
		logic        up, r, one, w;
		{ref_clk, sys_rst, slow, upstream_wide_request_n} = 4'h7;
		{up_bus_rst_n, dn_bus_rst_n, tgt_cyc, tgt_rd_phase} = 4'h0;
		{req_valid, frame_drive, ln_addr_phase, ln_dac_first} = 4'h0;
		{ln_dac_second, ln_data_phase, ln_write, ln_ack64} = 4'h0;
		{ln_second, ln_last_odd, tgt_up, tgt_req64_n} = 4'h1;
		{tgt_multi, tgt_one_dw, req_up, req_prefetch} = 4'h0;
		{req_resume, req_prev_ack64, req_prev_retry} = 3'h0;
		{tgt_cmd, tgt_ad, tgt_data, tgt_rd_left} = '0;
		{req_cmd, req_addr_lo, req_dwords, ln_addr, ln_data, ln_be_n} = '0;
		void'($urandom(32'hb63f));
		up_bus_num = $urandom;
		dn_bus_num = up_bus_num ^ 8'h5a;
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'b0;
		repeat (6) @(posedge ref_clk);
		#1;
		chk({dn_wide_req_n_o, dn_wide_req_n_oe}, 2'h1);
		chk({up_wide_ok, up_wide_req_n_o, up_wide_req_n_oe}, 3'h3);
		@(posedge ref_clk);
		{up_bus_rst_n, dn_bus_rst_n} <= 2'h3;
		repeat (6) @(posedge ref_clk);
		upstream_wide_request_n <= 1'b0;
		repeat (6) @(posedge ref_clk);
		#1;
		chk(up_wide_ok, 0);
		wide_up = 1'b0;
		ini_rand(20);
		@(posedge ref_clk);
		up_bus_rst_n <= 1'b0;
		repeat (6) @(posedge ref_clk);
		up_bus_rst_n <= 1'b1;
		repeat (6) @(posedge ref_clk);
		#1;
		chk(up_wide_ok, 1);
		wide_up = 1'b1;
		ini_rand(30);
		for (int k = 0; k < 4; k++)
			sc_test(k[0], k[1]);
		for (int k = 0; k < 7; k++) begin
			a = {8'($urandom), dn_bus_num, PBSC_DEV_ALL, PBSC_FUNC_ALL,
				PBSC_REG_ZERO, PBSC_TYPE1};
			c = k == 5 ? PBSC_CMD_CFG_RD :
				k == 6 ? PBSC_CMD_SPECIAL : PBSC_CMD_CFG_WR;
			case (k)
			0: a[1:0] = 2'h0;
			1: a[15:11] = 5'h1e;
			2: a[10:8] = 3'h6;
			3: a[7:2] = 6'h01;
			4: a[23:16] = ~a[23:16];
			default: ;
			endcase
			tgt(1'b0, c, a, $urandom, 1'b0, 1'b0, 1'b0);
			chk({tgt_claim, ini_start, tgt_ack64}, 3'h0);
			chk(tgt_ignore, k == 6);
		end
		for (int k = 0; k < 40; k++) begin
			c = 4'($urandom);
			{up, r, one} = 3'($urandom);
			one = one && c != PBSC_CMD_MEM_WR;
			if (c == PBSC_CMD_CFG_WR || c == PBSC_CMD_SPECIAL)
				c = PBSC_CMD_IO_RD;
			// Every command outside the refused classes gets the wide answer
			w = !r && !one && (up || wide_up) && !(c inside {PBSC_CMD_MEM_RD,
				PBSC_CMD_IO_RD, PBSC_CMD_IO_WR, PBSC_CMD_CFG_RD});
			tgt(up, c, $urandom, $urandom, 1'b0, r, one);
			chk(tgt_ack64, w);
			if (c != PBSC_CMD_MEM_WR) begin
				rd(8'h1);
				chk(tgt_disc_early, w);
				rd(8'h2);
				chk(tgt_disc_early, 0);
			end
		end
		$display("target width test done");
		ini_one(1'b0, PBSC_CMD_MEM_WR, 5'h0, 8'h8, 1'b0, 1'b0, 1'b0, 1'b0);
		for (int k = 0; k < 7; k++) begin
			if (k == 4)
				ini_one(1'b0, PBSC_CMD_MEM_RL, 5'h0, 8'h8, 1'b1, 1'b0, 1'b0, 1'b0);
			lane(k);
		end
		$display("lane test done");
		chk(n_rma, 0);
		chk(n_starts, 4);
		complete_run();
	end
endmodule
`default_nettype wire
